// ===== fpm_pkg.sv
// shared constants for the flash and panel pin multiplexer
package fpm_pkg;
   // ----------------------------------------
   // panel width codes
   // ----------------------------------------
   localparam logic [1:0] WIDTH_24 = 2'h0;
   localparam logic [1:0] WIDTH_18 = 2'h1;
   localparam logic [1:0] WIDTH_16 = 2'h2;
   localparam logic [1:0] WIDTH_GPIO = 2'h3;
   // ----------------------------------------
   // sizes and reset values
   // ----------------------------------------
   localparam int PANEL_BITS = 24;
   localparam int PIXEL_BITS = 24;
   localparam int FIFO_DEPTH = 8;
   localparam int PCLK_DIV = 4;
   localparam logic [4:0] GPC_DIR_RESET = 5'h00;
   // ----------------------------------------
   // port c bit positions
   // ----------------------------------------
   localparam int GPC_CLK = 0;
   localparam int GPC_MO = 1;
   localparam int GPC_MI = 2;
   localparam int GPC_CS0 = 3;
   localparam int GPC_CS1 = 4;
endpackage

// ===== fpm_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module fpm_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("fifo depth must be a power of two of at least 2");
      end
   end
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } fpm_fifo_s;
   fpm_fifo_s st_q, st_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic push, pop;
   assign in_ready_o = (st_q.wr - st_q.rd) != (AW+1)'(DEPTH);
   assign out_valid_o = st_q.wr != st_q.rd;
   assign out_data_o = mem_q[st_q.rd[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_comb begin
      st_d = st_q;
      if (push) begin
         st_d.wr = st_q.wr + 1'b1;
      end
      if (pop) begin
         st_d.rd = st_q.rd + 1'b1;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
      if (push) begin
         mem_q[st_q.wr[AW-1:0]] <= in_data_i;
      end
   end
endmodule

// ===== fpm_top.sv
// flash port and tft panel pin multiplexer
//
// What this block does
// (RL1) two active-low flash chip selects, zero and one
// (RL2) serial clock driven out while port enabled
// (RL3) single mode: master out driven, in sampled
// (RL4) dual mode: both data lines bidirectional, dma only
// (RL5) port disabled: five pins become port c gpio, inputs after reset
// (RL6) width 00b: full 24-bit rgb on panel bus
// (RL7) width 01b: 18-bit rgb, six lines to port d
// (RL8) width 10b: 16-bit rgb, rest to port d
// (RL9) width 11b: no pixels, ports d e f
// (RL10) panel clock derived from internal pll clock
// (RL11) vertical and horizontal sync outputs
// (RL12) data valid marks pixel cycles
`timescale 1ns/10ps
module fpm_top #(
   parameter int PCLK_DIV = fpm_pkg::PCLK_DIV
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   // serial master side
   input wire logic spi_enable_i,
   input wire logic dual_mode_i,
   input wire logic dma_active_i,
   input wire logic flash_select_0_n_i,
   input wire logic flash_select_1_n_i,
   input wire logic flash_serial_clock_i,
   input wire logic [1:0] dual_out_i,
   input wire logic dual_out_en_i,
   output logic [1:0] flash_in_o,
   // port c controls
   input wire logic [4:0] gp_port_c_out_i,
   input wire logic [4:0] gp_port_c_dir_i,
   input wire logic gp_port_c_dir_we_i,
   output logic [4:0] gp_port_c_in_o,
   // pins of the flash port
   input wire logic [4:0] flash_pin_i,
   output logic [4:0] flash_pin_o,
   output logic [4:0] flash_pin_oe_o,
   // panel side
   input wire logic [1:0] panel_width_i,
   input wire logic [23:0] pixel_i,
   input wire logic pixel_valid_i,
   output logic pixel_ready_o,
   input wire logic vsync_i,
   input wire logic hsync_i,
   input wire logic [7:0] gp_port_d_out_i,
   input wire logic [7:0] gp_port_d_oe_i,
   input wire logic [7:0] gp_port_e_out_i,
   input wire logic [7:0] gp_port_f_out_i,
   input wire logic [4:0] key_strobe_i,
   output logic [7:0] gp_port_d_in_o,
   output logic [4:0] key_input_o,
   input wire logic [23:0] panel_data_bus_i,
   output logic [23:0] panel_data_bus_o,
   output logic [23:0] panel_data_bus_oe_o,
   output logic panel_clock_o,
   output logic panel_vsync_o,
   output logic panel_hsync_o,
   output logic panel_data_valid_o
);
   localparam int DW = $clog2(PCLK_DIV);
   initial begin
      if (PCLK_DIV < 2 || PCLK_DIV % 2 != 0) begin
         $error("panel clock divider must be even and at least 2");
      end
   end
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [4:0] gpc_dir;
      logic [4:0] s1, s2, s3;
      logic [4:0] pin_in;
      logic [4:0] fo, foe;
      logic [DW-1:0] div;
      logic pclk;
      logic [23:0] pd, pdoe;
      logic vs, hs, de;
      logic [23:0] pd_s1, pd_s2, pd_s3, pd_in;
   } fpm_top_s;
   fpm_top_s st_q, st_d;
   logic [23:0] fifo_data;
   logic fifo_valid, fifo_take, tick;

   // d/e/f gpio source for one panel line in non-pixel roles
   function automatic logic [1:0] gp_of(input logic [1:0] w,
                                        input int i);
      // returns 1 for port d, 2 for e/f, 0 for pixel
      logic [1:0] r;
      r = 2'h0;
      if (w == fpm_pkg::WIDTH_GPIO) begin
         r = (i inside {0,1,2,8,9,16,17,18}) ? 2'h1 : 2'h2;
      end else if (w == fpm_pkg::WIDTH_16) begin
         r = (i inside {0,1,2,8,9,16,17,18}) ? 2'h1 : 2'h0;
      end else if (w == fpm_pkg::WIDTH_18) begin
         r = (i inside {0,1,8,9,16,17}) ? 2'h1 : 2'h0;
      end
      return r;
   endfunction

   // colour bit placed on a line for the current width
   function automatic logic pix_of(input logic [1:0] w,
                                   input logic [23:0] p,
                                   input int i);
      logic b;
      int sh;
      b = 1'b0;
      sh = (w == fpm_pkg::WIDTH_18) ? 2 : 3;
      if (w == fpm_pkg::WIDTH_24) begin
         b = p[i];
      end else if (i < 8) begin
         b = p[i - sh];
      end else if (i < 16) begin
         b = p[i - 2];
      end else begin
         b = p[i - sh];
      end
      return b;
   endfunction

   // port d bit numbers of lines 0,1,2,8,9,16,17,18
   localparam int DMAP [24] = '{0,1,6,0,0,0,0,0,2,3,0,0,0,0,0,0,
                                4,5,7,0,0,0,0,0};

   // ----------------------------------------
   // pixel buffer: drained one word per panel clock
   // ----------------------------------------
   fpm_fifo #(
      .WIDTH(fpm_pkg::PIXEL_BITS),
      .DEPTH(fpm_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .in_data_i(pixel_i),
      .in_valid_i(pixel_valid_i),
      .in_ready_o(pixel_ready_o),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_take)
   );

   assign tick = st_q.div == DW'(PCLK_DIV - 1);
   // pixels only leave on the falling panel edge so the panel sees stable data
   assign fifo_take = tick && st_q.pclk &&
                      panel_width_i != fpm_pkg::WIDTH_GPIO;

   always_comb begin
      st_d = st_q;
      // port c direction, inputs after reset
      if (gp_port_c_dir_we_i) begin
         st_d.gpc_dir = gp_port_c_dir_i; // [RL5]
      end
      // three-stage pin sampling, change counts when stages 2 and 3 agree
      st_d.s1 = flash_pin_i;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int k = 0; k < 5; k++) begin
         if (st_q.s2[k] == st_q.s3[k]) begin
            st_d.pin_in[k] = st_q.s3[k];
         end
      end
      st_d.pd_s1 = panel_data_bus_i;
      st_d.pd_s2 = st_q.pd_s1;
      st_d.pd_s3 = st_q.pd_s2;
      for (int k = 0; k < 24; k++) begin
         if (st_q.pd_s2[k] == st_q.pd_s3[k]) begin
            st_d.pd_in[k] = st_q.pd_s3[k];
         end
      end
      // flash pins
      if (spi_enable_i) begin
         st_d.fo[fpm_pkg::GPC_CS0] = flash_select_0_n_i; // [RL1]
         st_d.fo[fpm_pkg::GPC_CS1] = flash_select_1_n_i; // [RL1]
         st_d.foe[fpm_pkg::GPC_CS0] = 1'b1;
         st_d.foe[fpm_pkg::GPC_CS1] = 1'b1;
         st_d.fo[fpm_pkg::GPC_CLK] = flash_serial_clock_i; // [RL2]
         st_d.foe[fpm_pkg::GPC_CLK] = 1'b1; // [RL2]
         st_d.fo[fpm_pkg::GPC_MO] = dual_out_i[0]; // [RL3]
         st_d.fo[fpm_pkg::GPC_MI] = dual_out_i[1];
         if (dual_mode_i && dma_active_i) begin
            st_d.foe[fpm_pkg::GPC_MO] = dual_out_en_i; // [RL4]
            st_d.foe[fpm_pkg::GPC_MI] = dual_out_en_i; // [RL4]
         end else begin
            st_d.foe[fpm_pkg::GPC_MO] = 1'b1; // [RL3]
            st_d.foe[fpm_pkg::GPC_MI] = 1'b0; // [RL3]
         end
      end else begin
         st_d.fo = gp_port_c_out_i; // [RL5]
         st_d.foe = st_q.gpc_dir; // [RL5]
      end
      // panel clock divider
      st_d.div = tick ? '0 : DW'(st_q.div + 1'b1);
      if (tick) begin
         st_d.pclk = ~st_q.pclk; // [RL10]
      end
      if (fifo_take || (tick && st_q.pclk)) begin
         st_d.vs = vsync_i; // [RL11]
         st_d.hs = hsync_i; // [RL11]
         st_d.de = fifo_take && fifo_valid; // [RL12]
      end
      // panel data bus per line
      for (int i = 0; i < 24; i++) begin
         case (gp_of(panel_width_i, i))
            2'h1: begin
               st_d.pd[i] = gp_port_d_out_i[DMAP[i]]; // [RL7] [RL8]
               st_d.pdoe[i] = gp_port_d_oe_i[DMAP[i]];
               if (i == 9 || i == 16 || i == 17 || i == 18) begin
                  // key strobes are open drain: drive low only
                  if (!gp_port_d_oe_i[DMAP[i]]) begin
                     st_d.pd[i] = 1'b0;
                     st_d.pdoe[i] = ~key_strobe_i[i == 9 ? 3 :
                        (i == 16 ? 1 : (i == 17 ? 2 : 4))];
                  end
               end
            end
            2'h2: begin
               // index cut to three bits so unrolled lines never select
               // outside the eight-bit port
               if (i >= 13) begin
                  st_d.pd[i] =
                     gp_port_f_out_i[3'(i < 16 ? i - 13 : i - 16)]; // [RL9]
               end else begin
                  st_d.pd[i] =
                     gp_port_e_out_i[3'(i < 8 ? i - 3 : i - 5)]; // [RL9]
               end
               st_d.pdoe[i] = 1'b1; // [RL9]
            end
            default: begin
               st_d.pdoe[i] = 1'b1; // [RL6]
               if (fifo_take) begin
                  st_d.pd[i] = fifo_valid ?
                     pix_of(panel_width_i, fifo_data, i) : 1'b0; // [RL6] [RL7] [RL8]
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         st_q <= '0;
         st_q.gpc_dir <= fpm_pkg::GPC_DIR_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign flash_pin_o = st_q.fo;
   assign flash_pin_oe_o = st_q.foe;
   assign gp_port_c_in_o = st_q.pin_in;
   assign flash_in_o = {st_q.pin_in[fpm_pkg::GPC_MI],
                        st_q.pin_in[fpm_pkg::GPC_MO]}; // [RL3]
   assign gp_port_d_in_o = {st_q.pd_in[18], st_q.pd_in[2], st_q.pd_in[17],
                            st_q.pd_in[16], st_q.pd_in[9], st_q.pd_in[8],
                            st_q.pd_in[1], st_q.pd_in[0]};
   assign key_input_o = {st_q.pd_in[2], st_q.pd_in[8], st_q.pd_in[1],
                         st_q.pd_in[0], 1'b1};
   assign panel_data_bus_o = st_q.pd;
   assign panel_data_bus_oe_o = st_q.pdoe;
   assign panel_clock_o = st_q.pclk;
   assign panel_vsync_o = st_q.vs;
   assign panel_hsync_o = st_q.hs;
   assign panel_data_valid_o = st_q.de;
endmodule

// ===== fpm_properties.sv
// concurrent checks on the pin multiplexer ports
`timescale 1ns/10ps
module fpm_properties #(
   parameter int PCLK_DIV = 4
) (
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic spi_enable_i,
   input wire logic dual_mode_i,
   input wire logic dma_active_i,
   input wire logic flash_select_0_n_i,
   input wire logic flash_serial_clock_i,
   input wire logic [1:0] dual_out_i,
   input wire logic dual_out_en_i,
   input wire logic [4:0] flash_pin_i,
   input wire logic [4:0] flash_pin_o,
   input wire logic [4:0] flash_pin_oe_o,
   input wire logic [1:0] flash_in_o,
   input wire logic [1:0] panel_width_i,
   input wire logic panel_clock_o,
   input wire logic panel_data_valid_o
);
   logic [1:0] run_q;
   logic dual_w;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   assign dual_w = dual_mode_i && dma_active_i;
   // outputs stay low one edge after reset, so wait two
   always_ff @(posedge sys_clk_i) begin
      run_q <= reset_i ? 2'h0 : {run_q[0], 1'h1};
   end
   chk_select_clock: assert property (
      run_q[1] && spi_enable_i && $past(spi_enable_i) |->
      flash_pin_oe_o[0] && flash_pin_oe_o[3] &&
      flash_pin_o[0] == $past(flash_serial_clock_i) &&
      flash_pin_o[3] == $past(flash_select_0_n_i))
      else $error("select or clock pin wrong");
   chk_single_line: assert property (
      run_q[1] && spi_enable_i && !dual_mode_i &&
      $past(spi_enable_i && !dual_mode_i) |->
      flash_pin_oe_o[2:1] == 2'h1 && flash_pin_o[1] == $past(dual_out_i[0]))
      else $error("single line pins wrong");
   chk_dual_lines: assert property (
      run_q[1] && spi_enable_i && dual_w && $past(spi_enable_i && dual_w)
      |-> flash_pin_oe_o[2:1] == {2{$past(dual_out_en_i)}} &&
      (!$past(dual_out_en_i) || flash_pin_o[2:1] == $past(dual_out_i)))
      else $error("dual line pins wrong");
   chk_gpio_input: assert property ($fell(reset_i) |->
      flash_pin_oe_o == 5'h00) else $error("port c not input at reset");
   chk_line_sample: assert property (
      $stable(flash_pin_i) [*8] |-> flash_in_o == flash_pin_i[2:1])
      else $error("sampled data lines wrong");
   chk_valid_stands: assert property (
      $rose(panel_data_valid_o) |-> panel_data_valid_o [*8])
      else $error("data valid too short");
   chk_scan_clock: assert property (
      run_q[1] && $changed(panel_clock_o) |=> $stable(panel_clock_o) [*3]
      ##1 $changed(panel_clock_o)) else $error("panel clock period wrong");
   chk_no_pixels: assert property (
      (panel_width_i == 2'h3) [*8] |=> !panel_data_valid_o)
      else $error("pixels driven in gpio width");
   cov_dual: cover property (spi_enable_i && dual_w && dual_out_en_i);
   cov_pixel: cover property ($rose(panel_data_valid_o));
   cov_narrow: cover property (panel_width_i == 2'h1 && panel_data_valid_o);
endmodule
bind fpm_top fpm_properties #(.PCLK_DIV(PCLK_DIV)) chk (.*);

// ===== fpm_far_model.sv
// far side model: flash device on released pins and a capturing panel
`timescale 1ns/10ps
module fpm_far_model (
   input wire logic [4:0] pin_out_i,
   input wire logic [4:0] pin_oe_i,
   input wire logic [4:0] slave_drive_i,
   output logic [4:0] pin_level_o,
   input wire logic [23:0] bus_out_i,
   input wire logic [23:0] bus_oe_i,
   output logic [23:0] bus_level_o,
   input wire logic panel_clock_i,
   input wire logic data_valid_i,
   output logic [23:0] capture_o,
   output int count_o
);
   // the slave drives only lines the master has released
   assign pin_level_o = (pin_oe_i & pin_out_i) |
      (~pin_oe_i & slave_drive_i);
   // key inputs are pulled up, so released panel lines read high
   assign bus_level_o = (bus_oe_i & bus_out_i) | ~bus_oe_i;
   initial count_o = 0;
   always @(posedge panel_clock_i) begin
      if (data_valid_i === 1'h1) begin
         capture_o <= bus_out_i;
         count_o <= count_o + 1;
      end
   end
endmodule

// ===== testbench.sv
// self-checking bench for the pin multiplexer
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
 error_cnt++; $display("Error %s exp %h got %h", n, e, a); end end
module testbench;
   logic sys_clk_i = 1'h0, reset_i = 1'h1, spi_enable_i = 1'h0;
   logic dual_mode_i = 1'h0, dma_active_i = 1'h0, dual_out_en_i = 1'h0;
   logic flash_select_0_n_i = 1'h1, flash_select_1_n_i = 1'h1;
   logic flash_serial_clock_i = 1'h0, gp_port_c_dir_we_i = 1'h0;
   logic pixel_valid_i = 1'h0, vsync_i = 1'h0, hsync_i = 1'h0;
   logic [1:0] dual_out_i = 2'h0, panel_width_i = 2'h0, flash_in_o;
   logic [4:0] gp_port_c_out_i = 5'h00, gp_port_c_dir_i = 5'h00;
   logic [4:0] key_strobe_i = 5'h00, ext = 5'h00, key_input_o;
   logic [7:0] gp_port_d_out_i = 8'h00, gp_port_d_oe_i = 8'h00;
   logic [7:0] gp_port_e_out_i = 8'h00, gp_port_f_out_i = 8'h00;
   logic [23:0] pixel_i = 24'h000000, panel_data_bus_i, cap;
   logic [4:0] flash_pin_i, flash_pin_o, flash_pin_oe_o, gp_port_c_in_o;
   logic [7:0] gp_port_d_in_o;
   logic [23:0] panel_data_bus_o, panel_data_bus_oe_o;
   logic pixel_ready_o, panel_clock_o, panel_vsync_o, panel_hsync_o;
   logic panel_data_valid_o;
   int error_cnt = 0, num_checks = 0, cnt;
   fpm_top uut (.*);
   fpm_far_model far (.pin_out_i(flash_pin_o), .pin_oe_i(flash_pin_oe_o),
      .slave_drive_i(ext), .pin_level_o(flash_pin_i),
      .bus_out_i(panel_data_bus_o), .bus_oe_i(panel_data_bus_oe_o),
      .bus_level_o(panel_data_bus_i), .panel_clock_i(panel_clock_o),
      .data_valid_i(panel_data_valid_o), .capture_o(cap), .count_o(cnt));
   always #4 sys_clk_i = ~sys_clk_i;
   task tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task bound(input int k);
      if (k >= 200) begin
         error_cnt++;
         summarize();
      end
   endtask
   task summarize;
      if (error_cnt == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task t_gpio;
      ext = 5'h15;
      tick(10);
      `CHK("port c oe", 5'h00, flash_pin_oe_o)
      `CHK("port c in", 5'h15, gp_port_c_in_o)
      {gp_port_c_dir_i, gp_port_c_out_i, gp_port_c_dir_we_i} = 11'h7D5;
      tick(1);
      gp_port_c_dir_we_i = 1'h0;
      tick(4);
      `CHK("port c out", 5'h0A, flash_pin_o)
      `CHK("port c dir", 5'h1F, flash_pin_oe_o)
   endtask
   task t_spi;
      {spi_enable_i, flash_select_0_n_i, flash_serial_clock_i} = 3'h5;
      {dual_out_i, ext} = 7'h24;
      tick(10);
      `CHK("spi oe", 5'h1B, flash_pin_oe_o)
      `CHK("spi pins", 5'h13, flash_pin_o & 5'h1B)
      `CHK("spi in", 2'h3, flash_in_o)
      {flash_select_0_n_i, flash_select_1_n_i} = 2'h2;
      {flash_serial_clock_i, dual_out_i, ext} = 8'h00;
      tick(10);
      `CHK("spi pins", 5'h08, flash_pin_o & 5'h1B)
      `CHK("spi in", 2'h0, flash_in_o)
   endtask
   task t_dual;
      dual_mode_i = 1'h1;
      tick(10);
      `CHK("no dma oe", 5'h1B, flash_pin_oe_o)
      {dma_active_i, dual_out_en_i, dual_out_i} = 4'hE;
      tick(10);
      `CHK("dual oe", 5'h1F, flash_pin_oe_o)
      `CHK("dual out", 2'h2, flash_pin_o[2:1])
      {dual_out_en_i, ext} = 6'h06;
      tick(10);
      `CHK("dual in", 2'h3, flash_in_o)
      {dual_mode_i, dma_active_i} = 2'h0;
   endtask
   task t_sync;
      vsync_i = 1'h1;
      tick(20);
      `CHK("sync out", 2'h2, {panel_vsync_o, panel_hsync_o})
      {vsync_i, hsync_i} = 2'h1;
      tick(20);
      `CHK("sync out", 2'h1, {panel_vsync_o, panel_hsync_o})
   endtask
   task t_width(input logic [1:0] w, input logic [23:0] p, e, m);
      int k, c;
      {panel_width_i, pixel_i, pixel_valid_i} = {w, p, 1'h1};
      c = cnt;
      for (k = 0; k < 200 && pixel_ready_o !== 1'h1; k++) tick(1);
      bound(k);
      tick(1);
      pixel_valid_i = 1'h0;
      for (k = 0; k < 200 && cnt == c; k++) tick(1);
      bound(k);
      `CHK("pixel lines", e, cap & m)
      `CHK("pixel oe", m, panel_data_bus_oe_o & m)
   endtask
   task t_port_d;
      {panel_width_i, gp_port_d_out_i, gp_port_d_oe_i} = 18'h2A50F;
      key_strobe_i = 5'h12;
      tick(10);
      `CHK("port d lines", 24'h000101, panel_data_bus_o & 24'h070307)
      `CHK("port d oe", 24'h020303, panel_data_bus_oe_o & 24'h070307)
      `CHK("port d in", 8'hD5, gp_port_d_in_o)
      `CHK("key in", 5'h1B, key_input_o)
   endtask
   task t_fill;
      int n, c;
      logic [23:0] x;
      {panel_width_i, gp_port_e_out_i, gp_port_f_out_i} = 18'h3A53C;
      x = {gp_port_f_out_i[7:3], 3'h0, gp_port_f_out_i[2:0],
         gp_port_e_out_i[7:5], 2'h0, gp_port_e_out_i[4:0], 3'h0};
      tick(12);
      c = cnt;
      pixel_valid_i = 1'h1;
      for (n = 0; n < 20 && pixel_ready_o === 1'h1; n++) tick(1);
      pixel_valid_i = 1'h0;
      tick(20);
      `CHK("fifo depth", fpm_pkg::FIFO_DEPTH, n)
      `CHK("gpio lines", x, panel_data_bus_o & 24'hF8FCF8)
      `CHK("no pixels", c, cnt)
      panel_width_i = 2'h0;
      for (n = 0; n < 200 && cnt != c + 8; n++) tick(1);
      bound(n);
      `CHK("ready again", 1'h1, pixel_ready_o)
   endtask
   initial begin
      tick(20);
      reset_i = 1'h0;
      tick(2);
      t_gpio();
      t_spi();
      t_dual();
      t_sync();
      t_width(2'h0, 24'hA5C3E1, 24'hA5C3E1, 24'hFFFFFF);
      t_width(2'h1, 24'h2A152B, {6'h2A, 2'h0, 6'h15, 2'h0, 6'h2B, 2'h0},
         24'hFCFCFC);
      t_width(2'h2, 24'h151A0B, {5'h15, 3'h0, 6'h1A, 2'h0, 5'h0B, 3'h0},
         24'hF8FCF8);
      t_port_d();
      t_fill();
      summarize();
   end
endmodule
